/* design/iso_params.svh */
// Constants for the five-instruction decode and execute block
`ifndef ISO_PARAMS_SVH
`define ISO_PARAMS_SVH
`define ISO_OP_HI        13
`define ISO_OP_LO        8
`define ISO_OP_INC_SKIP  6'h0F
`define ISO_OP_OR_LIT    6'h1A
`define ISO_OP_OR_FILE   6'h04
`define ISO_OP_COPY_FILE 6'h08
`define ISO_OP_LOAD_LIT  6'h19
`define ISO_DEST_BIT     7
`define ISO_FADDR_HI     6
`define ISO_LIT_HI       7
`define ISO_ACC_RESET    8'h00
`define ISO_ZERO_RESET   1'h0
`endif

/* design/iso_pkg.sv */
// Types for the five-instruction decode and execute block
package iso_pkg;
	typedef enum logic [2:0]
	{
		ISO_OTHER     = 3'h0,
		ISO_INC_SKIP  = 3'h1,
		ISO_OR_LIT    = 3'h2,
		ISO_OR_FILE   = 3'h3,
		ISO_COPY_FILE = 3'h4,
		ISO_LOAD_LIT  = 3'h5
	} iso_op_t;

	typedef enum logic [0:0]
	{
		ISO_RUN  = 1'b0,
		ISO_SKIP = 1'b1
	} iso_state_t;

	typedef struct packed
	{
		iso_op_t    op;
		logic       to_file;
		logic [6:0] faddr;
		logic [7:0] lit;
	} iso_dec_t;

	typedef struct packed
	{
		logic       we;
		logic [6:0] addr;
		logic [7:0] data;
	} iso_fwr_t;
endpackage

/* design/iso_decode.sv */
// Instruction word decoder
`timescale 1ns/1ps
`include "iso_params.svh"
module iso_decode
(
	input  wire logic [13:0]     instr,
	output iso_pkg::iso_dec_t    dec
);
	logic [5:0] top;
	assign top = instr[`ISO_OP_HI:`ISO_OP_LO];

	always_comb
	begin
		dec.op      = iso_pkg::ISO_OTHER;
		dec.to_file = instr[`ISO_DEST_BIT];
		dec.faddr   = instr[`ISO_FADDR_HI:0];
		dec.lit     = instr[`ISO_LIT_HI:0];
		case (top)
			`ISO_OP_INC_SKIP:  dec.op = iso_pkg::ISO_INC_SKIP;   // RL1
			`ISO_OP_OR_LIT:    dec.op = iso_pkg::ISO_OR_LIT;     // RL3
			`ISO_OP_OR_FILE:   dec.op = iso_pkg::ISO_OR_FILE;    // RL4
			`ISO_OP_COPY_FILE:
			begin
				if (!instr[`ISO_DEST_BIT])
				begin
					dec.op = iso_pkg::ISO_COPY_FILE;             // RL5
				end
			end
			`ISO_OP_LOAD_LIT:  dec.op = iso_pkg::ISO_LOAD_LIT;   // RL6
			default:           dec.op = iso_pkg::ISO_OTHER;
		endcase
	end
endmodule

/* design/iso_exec.sv */
// Execute stage for five accumulator instructions
//
// Behaviour
// RL1 - Increment file, result to acc or file
// RL2 - Zero increment result skips next instruction as no-op
// RL3 - OR literal into acc, sets zero flag
// RL4 - OR acc with file, acc or file
// RL5 - Copy file to acc, flags untouched
// RL6 - Load literal into acc, flags untouched
// RL7 - Zero flag set when an OR result is zero
`timescale 1ns/1ps
`include "iso_params.svh"
module iso_exec
(
	input  wire logic            clk,
	input  wire logic            reset_n,
	input  wire logic            clk_en,
	input  wire logic            instr_valid,
	input  wire logic [13:0]     instr,
	input  wire logic [7:0]      file_rdata,
	output logic [6:0]           file_raddr,
	output iso_pkg::iso_fwr_t    file_wr,
	output logic [7:0]           acc,
	output logic                 zero_flag,
	output logic                 skipping,
	output logic                 known_op
);
	// ==========================================
	// Decode
	iso_pkg::iso_dec_t    dec;
	iso_pkg::iso_state_t  state_r;
	iso_pkg::iso_state_t  state_nxt;
	logic [7:0]           acc_r;
	logic [7:0]           acc_nxt;
	logic                 zero_r;
	logic                 zero_nxt;
	iso_pkg::iso_fwr_t    fwr_r;
	iso_pkg::iso_fwr_t    fwr_nxt;
	logic [7:0]           result;
	logic                 go;
	logic                 squash;
	logic                 to_acc;
	logic                 to_file;

	// ==========================================
	// Functions
	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction

	function automatic logic has_dest(input iso_pkg::iso_op_t op);
		has_dest = (op == iso_pkg::ISO_INC_SKIP)
			|| (op == iso_pkg::ISO_OR_FILE);
	endfunction

	function automatic logic sets_zero(input iso_pkg::iso_op_t op);
		sets_zero = (op == iso_pkg::ISO_OR_LIT)
			|| (op == iso_pkg::ISO_OR_FILE);
	endfunction

	iso_decode iso_decode_inst
	(
		.instr (instr),
		.dec   (dec)
	);

	assign file_raddr = dec.faddr;
	assign go         = instr_valid && (state_r == iso_pkg::ISO_RUN);
	assign known_op   = dec.op != iso_pkg::ISO_OTHER;
	assign squash     = instr_valid && (state_r == iso_pkg::ISO_SKIP);
	assign to_file    = go && has_dest(dec.op) && dec.to_file;    // RL1
	assign to_acc     = go && known_op
		&& !(has_dest(dec.op) && dec.to_file);

	// ==========================================
	// Datapath
	always_comb
	begin
		case (dec.op)
			iso_pkg::ISO_INC_SKIP:
			begin
				result = file_rdata + 8'h01;             // RL1
			end
			iso_pkg::ISO_OR_LIT:
			begin
				result = acc_r | dec.lit;                // RL3
			end
			iso_pkg::ISO_OR_FILE:
			begin
				result = acc_r | file_rdata;             // RL4
			end
			iso_pkg::ISO_COPY_FILE:
			begin
				result = file_rdata;                     // RL5
			end
			iso_pkg::ISO_LOAD_LIT:
			begin
				result = dec.lit;                        // RL6
			end
			default:
			begin
				result = 8'h00;
			end
		endcase
	end

	// ==========================================
	// Skip control
	always_comb
	begin
		state_nxt = state_r;
		if (squash)
		begin
			state_nxt = iso_pkg::ISO_RUN;                // RL2
		end
		else if (go && dec.op == iso_pkg::ISO_INC_SKIP && is_zero(result))
		begin
			state_nxt = iso_pkg::ISO_SKIP;               // RL2
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= iso_pkg::ISO_RUN;
		end
		else if (clk_en)
		begin
			state_r <= state_nxt;
		end
	end

	// ==========================================
	// Accumulator
	always_comb
	begin
		acc_nxt = acc_r;
		if (to_acc)
		begin
			acc_nxt = result;                            // RL6
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			acc_r <= `ISO_ACC_RESET;
		end
		else if (clk_en)
		begin
			acc_r <= acc_nxt;
		end
	end

	// ==========================================
	// Zero flag
	always_comb
	begin
		zero_nxt = zero_r;
		if (go && sets_zero(dec.op))
		begin
			zero_nxt = is_zero(result);                  // RL7
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			zero_r <= `ISO_ZERO_RESET;
		end
		else if (clk_en)
		begin
			zero_r <= zero_nxt;
		end
	end

	// ==========================================
	// File write
	always_comb
	begin
		fwr_nxt      = '0;
		fwr_nxt.addr = dec.faddr;
		if (to_file)
		begin
			fwr_nxt.we   = 1'h1;                         // RL4
			fwr_nxt.data = result;
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			fwr_r.we   <= 1'h0;
			fwr_r.addr <= 7'h00;
			fwr_r.data <= 8'h00;
		end
		else if (clk_en)
		begin
			fwr_r.we   <= fwr_nxt.we;
			fwr_r.addr <= fwr_nxt.addr;
			fwr_r.data <= fwr_nxt.data;
		end
	end

	// ==========================================
	// Outputs
	assign acc       = acc_r;
	assign zero_flag = zero_r;
	assign file_wr   = fwr_r;
	assign skipping  = state_r == iso_pkg::ISO_SKIP;
endmodule

/* tb/iso_exec_assertions.sv */
// Checker for the execute block ports
`timescale 1ns/1ps
module iso_exec_chk
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              clk_en,
	input wire logic              instr_valid,
	input wire logic [13:0]       instr,
	input wire logic [7:0]        file_rdata,
	input wire iso_pkg::iso_fwr_t file_wr,
	input wire logic [7:0]        acc,
	input wire logic              zero_flag,
	input wire logic              skipping
);
	// ====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire t = clk_en && instr_valid && !skipping;
	wire [5:0] op = instr[13:8];
	load_acc_a: assert property (t && op == 6'h19 |=>
		acc == $past(instr[7:0]) && $stable(zero_flag)) else $error("load");
	or_lit_a: assert property (t && op == 6'h1A |=>
		acc == ($past(acc) | $past(instr[7:0]))) else $error("or lit");
	zero_set_a: assert property (t && op == 6'h1A |=>
		zero_flag == (acc == 8'h00)) else $error("zero");
	copy_acc_a: assert property (t && op == 6'h08 && !instr[7] |=>
		acc == $past(file_rdata) && $stable(zero_flag)) else $error("copy");
	inc_file_a: assert property (t && op == 6'h0F && instr[7] |=>
		file_wr.we && file_wr.data == $past(file_rdata) + 8'h01)
		else $error("inc");
	skip_set_a: assert property (t && op == 6'h0F |=>
		skipping == ($past(file_rdata) == 8'hFF)) else $error("skip");
	or_file_a: assert property (t && op == 6'h04 && instr[7] |=>
		file_wr.we && file_wr.data == ($past(acc) | $past(file_rdata)))
		else $error("or file");
	squash_nop_a: assert property (clk_en && instr_valid && skipping |=>
		!file_wr.we && !skipping && $stable(acc) && $stable(zero_flag))
		else $error("squash");
	inc_acc_a: assert property (t && op == 6'h0F && !instr[7] |=>
		acc == $past(file_rdata) + 8'h01 && $stable(zero_flag))
		else $error("inc acc");
	or_acc_a: assert property (t && op == 6'h04 && !instr[7] |=>
		acc == ($past(acc) | $past(file_rdata))) else $error("or acc");
	or_zero_a: assert property (t && op == 6'h04 |=>
		zero_flag == ($past(acc | file_rdata) == 8'h00))
		else $error("or zero");
	hold_state_a: assert property (!clk_en |=>
		$stable(acc) && $stable(zero_flag) && $stable(skipping))
		else $error("hold");
	c_skip: cover property (skipping && instr_valid);
	c_zero: cover property ($rose(zero_flag));
	c_wr: cover property (file_wr.we);
endmodule
bind iso_exec iso_exec_chk iso_exec_chk_inst (.clk(clk), .reset_n(reset_n),
	.clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
	.file_rdata(file_rdata), .file_wr(file_wr), .acc(acc),
	.zero_flag(zero_flag), .skipping(skipping));

/* tb/iso_exec_tb_top.sv */
// Testbench for the execute block
`timescale 1ns/1ps
module iso_exec_tb_top;
	// ====
	// Stimulus and instance
	logic              clk = 0, reset_n = 0, clk_en = 1, instr_valid = 0;
	logic [13:0]       instr = 14'h0000;
	logic [7:0]        file_rdata = 8'h00, acc;
	logic [6:0]        file_raddr;
	logic              zero_flag, skipping, known_op;
	iso_pkg::iso_fwr_t file_wr, fwr_seen;
	int                n_fail = 0, total_checks = 0, cyc = 0;
	iso_exec iso_exec_inst (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr(instr), .file_rdata(file_rdata),
		.file_raddr(file_raddr), .file_wr(file_wr), .acc(acc),
		.zero_flag(zero_flag), .skipping(skipping), .known_op(known_op));
	initial forever #20 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			report_and_stop();
		end
	end
	// ====
	// Tasks
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic run(logic [13:0] w, logic [7:0] rd);
		instr = w;
		file_rdata = rd;
		instr_valid = 1'b1;
		@(negedge clk);
		fwr_seen = file_wr;
		instr_valid = 1'b0;
		file_rdata = ~rd;
		@(negedge clk);
	endtask
	task automatic t_lit();
		run(14'h199A, 8'h00);
		chk("acc", 8'h9A, acc);
		run(14'h1A35, 8'h00);
		chk("acc", 8'hBF, acc);
		chk("z", 8'h00, zero_flag);
		run(14'h1900, 8'h00);
		run(14'h1A00, 8'h00);
		chk("z", 8'h01, zero_flag);
		$display("t_lit done");
	endtask
	task automatic t_file();
		run(14'h0805, 8'h91);
		chk("acc", 8'h91, acc);
		chk("z", 8'h01, zero_flag);
		run(14'h0490, 8'h13);
		chk("raddr", 8'h10, file_raddr);
		chk("we", 8'h01, fwr_seen.we);
		chk("addr", 8'h10, fwr_seen.addr);
		chk("data", 8'h93, fwr_seen.data);
		chk("we end", 8'h00, file_wr.we);
		chk("acc", 8'h91, acc);
		chk("z", 8'h00, zero_flag);
		run(14'h1900, 8'h00);
		run(14'h0410, 8'h00);
		chk("acc", 8'h00, acc);
		chk("z", 8'h01, zero_flag);
		chk("we", 8'h00, fwr_seen.we);
		run(14'h0410, 8'h13);
		chk("known", 8'h01, known_op);
		chk("acc", 8'h13, acc);
		chk("z", 8'h00, zero_flag);
		run(14'h0885, 8'h55);
		chk("known", 8'h00, known_op);
		chk("acc", 8'h13, acc);
		$display("t_file done");
	endtask
	task automatic t_inc();
		run(14'h0F85, 8'h41);
		chk("we", 8'h01, fwr_seen.we);
		chk("data", 8'h42, fwr_seen.data);
		chk("acc", 8'h13, acc);
		chk("skip", 8'h00, skipping);
		run(14'h0F05, 8'hFF);
		chk("acc", 8'h00, acc);
		chk("z", 8'h00, zero_flag);
		chk("we", 8'h00, fwr_seen.we);
		chk("skip", 8'h01, skipping);
		run(14'h1977, 8'h00);
		chk("acc", 8'h00, acc);
		chk("skip", 8'h00, skipping);
		run(14'h1977, 8'h00);
		chk("acc", 8'h77, acc);
		run(14'h0F05, 8'h41);
		chk("acc", 8'h42, acc);
		chk("skip", 8'h00, skipping);
		$display("t_inc done");
	endtask
	task automatic t_hold();
		clk_en = 1'b0;
		run(14'h195A, 8'h00);
		chk("acc", 8'h42, acc);
		clk_en = 1'b1;
		run(14'h195A, 8'h00);
		chk("acc", 8'h5A, acc);
		$display("t_hold done");
	endtask
	task automatic t_rst();
		run(14'h0F85, 8'hFF);
		chk("skip", 8'h01, skipping);
		reset_n = 1'b0;
		@(negedge clk);
		chk("acc", 8'h00, acc);
		chk("skip", 8'h00, skipping);
		chk("we", 8'h00, file_wr.we);
		reset_n = 1'b1;
		run(14'h1966, 8'h00);
		chk("acc", 8'h66, acc);
		$display("t_rst done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (6) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		t_lit();
		t_file();
		t_inc();
		t_hold();
		t_rst();
		report_and_stop();
	end
endmodule
